// ### hw/tsr_map.svh
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
// Summary of operation
// - fifo mode records all eight channels continuously for later reading
// - fifo overflow wraps to buffer start and flags error at next start command; a read clears it and flags only an overflow during the read
// - fifo buffer holds 8190 samples per channel
// - enabled diagnostic interrupt fires on error arrival and on its removal
// - enabled channel leaving its limit window raises that channel's interrupt
// - host acknowledges a process interrupt, device then clears it
// - no limit interrupts while scope or fifo mode is selected
// - writing the scope record during recording stops the recording
// - record byte 0 bits 2..0 hold trigger channel, default zero
// - byte 1 bits 6..0 hold pre-trigger percent, 00h to 64h
// - bytes 2,3 hold signed trigger level, 8100h up to 7EFFh
// - byte 4 bits 1..0: 00 rising, 01 falling, 10 manual start
// - manual start ignores trigger channel, pre-trigger and level
// - trigger when selected channel rises above or falls below level
// - scope samples readable only after the buffer is full or the manual length is recorded
// - in fifo mode reads are accepted any time after start
// - mode 01h starts, 00h reads over calls, 80h reads at once
// - reads return one selected channel; starts ignore the channel
// - scope reads begin at host offset; fifo reads ignore offset
// - fifo read gives all stored samples; error if destination too small
// - free microsecond counter latched at the edge trigger event
// - length: manual record count, scope read count returned, fifo ignores
// - scope memory of 65536 samples split over 1, 2, 4 or 8 channels
// - sample interval is factor times 100 us, 25 us for factor zero

// parameter record numbers
`define TSR_REC_SCOPE 8'hBE
`define TSR_REC_MODE  8'h7F
`define TSR_REC_LIM0  8'hA0
`define TSR_REC_CYC   8'hA8
// reset values
`define TSR_SCOPE_RST 40'h00_0000_0000
`define TSR_MODE_RST  16'h0000
`define TSR_UP_RST    16'h7FFF
`define TSR_LO_RST    16'h8000
`define TSR_CYC_RST   16'h0001
// operating mode codes, bits 5..1 of mode byte 0
`define TSR_OP_FIFO   5'h01
`define TSR_OP_SC1    5'h04
`define TSR_OP_SC8    5'h10
// command codes
`define TSR_CMD_START 8'h01
`define TSR_CMD_RDSEQ 8'h00
`define TSR_CMD_RDONE 8'h80
// trigger conditions
`define TSR_TC_RISE   2'b00
`define TSR_TC_FALL   2'b01
`define TSR_TC_MAN    2'b10
// return codes
`define TSR_RC_OK     16'h0000
`define TSR_RC_FIRST  16'h7001
`define TSR_RC_WAIT   16'h7023
`define TSR_RC_TRIG   16'h7013
`define TSR_RC_REC    16'h7003
`define TSR_RC_NOSTRT 16'h0004
`define TSR_RC_SMALL  16'h8200
`define TSR_RC_OVF    16'h8800
`define TSR_RC_NOCFG  16'h8002
`define TSR_RC_STOP   16'h8003
`define TSR_RC_CHAN   16'h8005
`define TSR_RC_OFFS   16'h8007
// sizes
`define TSR_MEM_WORDS 17'h1_0000
`define TSR_FIFO_DEP  13'd8190
`define TSR_PCT_MAX   7'h64
// timing
`define TSR_CLK_NS    20
`define TSR_TS_US     1
`define TSR_TS_CYC    (`TSR_TS_US * 1000 / `TSR_CLK_NS)
`define TSR_SLOW_US   25
`define TSR_SLOW_CYC  (`TSR_SLOW_US * 1000 / `TSR_CLK_NS)
`define TSR_STEP_US   100
`define TSR_STEP_CYC  (`TSR_STEP_US * 1000 / `TSR_CLK_NS)
`endif

// ### hw/tsr_pkg.sv
package tsr_pkg;
  typedef logic [7:0][15:0] tsr_smp_t;
  typedef struct packed {
    logic [7:0]  mode;
    logic [2:0]  chan;
    logic [15:0] offset;
    logic [16:0] len;
    logic [16:0] dest;
  } tsr_cmd_t;
  typedef struct packed {
    logic [15:0] ret;
    logic [16:0] len;
    logic [31:0] tstamp;
  } tsr_rsp_t;
  typedef enum logic [2:0] {
    TSR_R_OFF, TSR_R_ARM, TSR_R_POST, TSR_R_DONE, TSR_R_FIFO
  } tsr_rec_t;
  typedef enum logic [2:0] {
    TSR_C_IDLE, TSR_C_START, TSR_C_ISS, TSR_C_WAIT, TSR_C_LAT, TSR_C_PUSH
  } tsr_cmd_st_t;
endpackage : tsr_pkg

// ### hw/tsr_top.sv
`timescale 1ns/100ps
`include "tsr_map.svh"

// small fifo between memory readout and host
module tsr_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;
  logic          vld_ff;
  logic [W-1:0]  dat_ff;

  // valid and data leave from the output stage flops
  assign in_ready_o  = (cnt_ff != (AW+1)'(D));
  assign out_valid_o = vld_ff;
  assign out_data_o  = dat_ff;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = (cnt_ff != '0) && (!vld_ff || out_ready_i);

  // output stage, refilled when empty or taken
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vld_ff <= 1'b0;
      dat_ff <= '0;
    end else if (!vld_ff || out_ready_i) begin
      vld_ff <= (cnt_ff != '0);
      dat_ff <= mem_ff[rp_ff];
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tsr_fifo

module tsr_top
  import tsr_pkg::*;
#(
  parameter int STEP_CYC = `TSR_STEP_CYC,
  parameter int FIFO_D   = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        prm_wr_i,
  input  wire logic [7:0]  prm_rec_i,
  input  wire logic [39:0] prm_data_i,
  input  wire tsr_smp_t    smp_i,
  input  wire logic        diag_err_i,
  input  wire logic [7:0]  proc_ack_i,
  input  wire logic        req_i,
  input  wire tsr_cmd_t    cmd_i,
  output logic             busy_o,
  output tsr_rsp_t         rsp_o,
  output logic             rd_valid_o,
  output logic [15:0]      rd_data_o,
  input  wire logic        rd_ready_i,
  output logic             diag_irq_o,
  output logic [7:0]       proc_irq_o
);
  // memory address from channel and per-channel index
  function automatic logic [15:0] addr_f(input logic [2:0] ch,
      input logic [15:0] idx, input logic [1:0] lg, input logic ff);
    logic [15:0] a;
    a = ff ? {ch, idx[12:0]} : (16'(ch) << (5'd16 - 5'(lg))) | idx;
    return a;
  endfunction : addr_f

  logic [15:0]  mem [65536];
  logic [39:0]  scope_trigger_params_ff;
  logic [15:0]  mode_ff;
  logic [15:0]  cyc_ff;
  logic [15:0]  up_ff [8];
  logic [15:0]  lo_ff [8];
  tsr_rec_t     rec_ff;
  tsr_cmd_st_t  cst_ff;
  logic [23:0]  tcnt_ff;
  logic [5:0]   us_pre_ff;
  logic [31:0]  us_ff;
  tsr_smp_t     snap_ff;
  logic [2:0]   wch_ff;
  logic         wbusy_ff;
  logic [15:0]  wp_ff;
  logic [15:0]  widx_ff;
  logic [16:0]  fill_ff;
  logic [16:0]  left_ff;
  logic [16:0]  rlen_ff;
  logic [15:0]  start_ff;
  logic signed [15:0] prev_ff;
  logic         ovf_ff;
  logic [15:0]  raddr_ff;
  logic [15:0]  ridx_ff;
  logic [2:0]   rch_ff;
  logic [16:0]  rleft_ff;
  logic [15:0]  rq_ff;
  logic         diag_q_ff;
  logic [7:0]   in_win_ff;

  // decoded configuration
  logic [4:0]   op;
  logic         is_fifo;
  logic         is_scope;
  logic [1:0]   lg;
  logic [16:0]  share;
  logic [15:0]  mask;
  logic [3:0]   nch;
  logic [2:0]   tch;
  logic [6:0]   pct;
  logic signed [15:0] thr;
  logic [1:0]   cond;
  logic [16:0]  pre;
  logic [23:0]  period;
  logic         tick;
  logic         rec_on;
  logic         stop;
  logic         take;
  logic         fire;
  logic         rd_start;
  logic signed [15:0] cur;
  logic         f_full;
  logic         push_ok;
  logic         trig_hit;

  assign op       = mode_ff[5:1];
  assign is_fifo  = (op == `TSR_OP_FIFO);
  assign is_scope = (op[1:0] == 2'b00) && (op >= `TSR_OP_SC1)
                    && (op <= `TSR_OP_SC8);
  assign lg       = 2'(op[4:2] - 3'd1);
  assign share    = `TSR_MEM_WORDS >> lg;
  assign mask     = 16'(share - 17'd1);
  assign nch      = is_fifo ? 4'd8 : 4'(4'd1 << lg);
  assign tch      = scope_trigger_params_ff[2:0];
  assign pct      = (scope_trigger_params_ff[14:8] > `TSR_PCT_MAX)
                    ? `TSR_PCT_MAX : scope_trigger_params_ff[14:8];
  assign thr      = {scope_trigger_params_ff[23:16],
                     scope_trigger_params_ff[31:24]};
  assign cond     = scope_trigger_params_ff[33:32];
  // pre-trigger count, kept below the full share
  always_comb begin
    logic [23:0] p;
    p   = 24'((24'(share) * 24'(pct)) / 24'd100);
    pre = (p >= 24'(share)) ? 17'(share - 17'd1) : p[16:0];
  end
  // sample period from the cycle factor
  assign period   = (cyc_ff == '0) ? 24'(`TSR_SLOW_CYC)
                    : 24'(32'(cyc_ff) * 32'(STEP_CYC));
  assign tick     = (tcnt_ff >= period - 24'd1);
  assign rec_on   = (rec_ff == TSR_R_ARM) || (rec_ff == TSR_R_POST)
                    || (rec_ff == TSR_R_FIFO);
  // a scope, mode or cycle record write while recording stops it
  assign stop     = prm_wr_i && rec_on && ((prm_rec_i == `TSR_REC_SCOPE)
                    || (prm_rec_i == `TSR_REC_MODE)
                    || (prm_rec_i == `TSR_REC_CYC));
  assign take     = req_i && !busy_o;
  assign cur      = smp_i[tch];
  // threshold crossing on the trigger channel
  assign fire     = (cond == `TSR_TC_RISE) ? (prev_ff <= thr && cur > thr)
                    : (cond == `TSR_TC_FALL) && (prev_ff >= thr && cur < thr);
  assign f_full   = (fill_ff == 17'(`TSR_FIFO_DEP));
  // edge trigger accepted by the recorder this cycle
  assign trig_hit = tick && rec_on && !stop && (rec_ff == TSR_R_ARM)
                    && !(take && cmd_i.mode == `TSR_CMD_START)
                    && fire && (fill_ff >= pre);

  // parameter records
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scope_trigger_params_ff <= `TSR_SCOPE_RST;
      mode_ff                 <= `TSR_MODE_RST;
      cyc_ff                  <= `TSR_CYC_RST;
      for (int i = 0; i < 8; i++) begin
        up_ff[i] <= `TSR_UP_RST;
        lo_ff[i] <= `TSR_LO_RST;
      end
    end else if (prm_wr_i) begin
      if (prm_rec_i == `TSR_REC_SCOPE) begin
        scope_trigger_params_ff <= prm_data_i;
      end
      if (prm_rec_i == `TSR_REC_MODE) begin
        mode_ff <= prm_data_i[15:0];
      end
      if (prm_rec_i == `TSR_REC_CYC) begin
        cyc_ff <= {prm_data_i[7:0], prm_data_i[15:8]};
      end
      if (prm_rec_i[7:3] == `TSR_REC_LIM0 >> 3) begin
        up_ff[prm_rec_i[2:0]] <= {prm_data_i[7:0], prm_data_i[15:8]};
        lo_ff[prm_rec_i[2:0]] <= {prm_data_i[23:16], prm_data_i[31:24]};
      end
    end
  end

  // sample period counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick) begin
      tcnt_ff <= '0;
    end else begin
      tcnt_ff <= tcnt_ff + 24'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      us_pre_ff <= '0;
      us_ff     <= '0;
    end else if (us_pre_ff == 6'(`TSR_TS_CYC - 1)) begin
      us_pre_ff <= '0;
      us_ff     <= us_ff + 32'd1;
    end else begin
      us_pre_ff <= us_pre_ff + 6'd1;
    end
  end

  // snapshot all channels and write the nch used ones one per cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      snap_ff  <= '0;
      wch_ff   <= '0;
      wbusy_ff <= 1'b0;
    end else if (tick && rec_on && !stop) begin
      snap_ff  <= smp_i;
      wch_ff   <= '0;
      wbusy_ff <= 1'b1;
    end else if (wbusy_ff) begin
      wch_ff   <= wch_ff + 3'd1;
      wbusy_ff <= (4'(wch_ff) != nch - 4'd1);
    end
  end

  // sample memory
  always_ff @(posedge clk_i) begin
    if (wbusy_ff) begin
      mem[addr_f(wch_ff, widx_ff, lg, is_fifo)] <= snap_ff[wch_ff];
    end
    rq_ff <= mem[raddr_ff];
  end

  // recorder state, write index and trigger handling
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rec_ff   <= TSR_R_OFF;
      wp_ff    <= '0;
      widx_ff  <= '0;
      fill_ff  <= '0;
      left_ff  <= '0;
      rlen_ff  <= '0;
      start_ff <= '0;
      prev_ff  <= '0;
      ovf_ff   <= 1'b0;
    end else begin
      if (tick) begin
        prev_ff <= cur;
      end
      // overflow reported once, a new overflow wins the clear
      if (take) begin
        ovf_ff <= 1'b0;
      end
      if (stop) begin
        rec_ff <= TSR_R_OFF;
      end else if (take && cmd_i.mode == `TSR_CMD_START) begin
        wp_ff   <= '0;
        fill_ff <= '0;
        if (is_fifo) begin
          rec_ff <= TSR_R_FIFO;
        end else if (is_scope && cond == `TSR_TC_MAN) begin
          // manual start records the asked length
          rec_ff   <= TSR_R_POST;
          start_ff <= '0;
          rlen_ff  <= (cmd_i.len == '0 || cmd_i.len > share)
                      ? share : cmd_i.len;
          left_ff  <= (cmd_i.len == '0 || cmd_i.len > share)
                      ? share : cmd_i.len;
        end else if (is_scope) begin
          rec_ff  <= TSR_R_ARM;
          rlen_ff <= share;
        end
      end else if (tick && rec_on) begin
        widx_ff <= wp_ff;
        unique case (rec_ff)
          TSR_R_FIFO: begin
            // wrap at the fifo depth, flag overflow
            wp_ff <= (wp_ff == 16'(`TSR_FIFO_DEP - 1)) ? '0 : wp_ff + 16'd1;
            if (f_full) begin
              ovf_ff <= 1'b1;
            end
            fill_ff <= (rd_start ? 17'd0 : (f_full ? fill_ff - 17'd1
                        : fill_ff)) + 17'd1;
          end
          TSR_R_ARM: begin
            wp_ff   <= (wp_ff + 16'd1) & mask;
            fill_ff <= (fill_ff < share) ? fill_ff + 17'd1 : fill_ff;
            if (fire && fill_ff >= pre) begin
              rec_ff       <= (pre + 17'd1 == share) ? TSR_R_DONE
                              : TSR_R_POST;
              left_ff      <= 17'(share - pre - 17'd1);
              start_ff     <= (wp_ff - 16'(pre)) & mask;
            end
          end
          TSR_R_POST: begin
            wp_ff   <= (wp_ff + 16'd1) & mask;
            left_ff <= left_ff - 17'd1;
            if (left_ff == 17'd1) begin
              rec_ff <= TSR_R_DONE;
            end
          end
          default: begin
            wp_ff <= wp_ff;
          end
        endcase
      end else if (rd_start && is_fifo) begin
        fill_ff <= '0;
      end
    end
  end

  // command engine and readout
  tsr_fifo #(.W(16), .D(FIFO_D)) u_fifo (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (cst_ff == TSR_C_PUSH),
    .in_ready_o (push_ok),
    .in_data_i  (rq_ff),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o (rd_data_o)
  );

  assign rd_start = take && (cmd_i.mode == `TSR_CMD_RDSEQ
                    || cmd_i.mode == `TSR_CMD_RDONE)
                    && cst_ff == TSR_C_IDLE && rec_ff == TSR_R_FIFO
                    && fill_ff <= cmd_i.dest;

  // busy and return code follow the command
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cst_ff    <= TSR_C_IDLE;
      busy_o    <= 1'b0;
      rsp_o.ret <= `TSR_RC_OK;
      rsp_o.len <= '0;
      raddr_ff  <= '0;
      ridx_ff   <= '0;
      rch_ff    <= '0;
      rleft_ff  <= '0;
      rsp_o.tstamp <= '0;
    end else begin
      // timestamp latched at the trigger event
      if (trig_hit) begin
        rsp_o.tstamp <= us_ff;
      end
      unique case (cst_ff)
        TSR_C_IDLE: begin
          if (take) begin
            if (!is_fifo && !is_scope) begin
              rsp_o.ret <= `TSR_RC_NOCFG;
            end else if (cmd_i.mode == `TSR_CMD_START) begin
              if (is_fifo) begin
                rsp_o.ret <= ovf_ff ? `TSR_RC_OVF : `TSR_RC_OK;
              end else begin
                busy_o    <= 1'b1;
                cst_ff    <= TSR_C_START;
                rsp_o.ret <= (cond == `TSR_TC_MAN) ? `TSR_RC_TRIG
                             : `TSR_RC_WAIT;
              end
            end else if (cmd_i.mode != `TSR_CMD_RDSEQ
                         && cmd_i.mode != `TSR_CMD_RDONE) begin
              rsp_o.ret <= `TSR_RC_NOCFG;
            end else if (rec_ff == TSR_R_OFF) begin
              rsp_o.ret <= `TSR_RC_NOSTRT;
            // scope data only after the buffer is full or the manual length is recorded
            end else if (is_scope && (rec_ff != TSR_R_DONE
                         || wbusy_ff)) begin
              rsp_o.ret <= `TSR_RC_REC;
            end else if (4'(cmd_i.chan) >= nch) begin
              rsp_o.ret <= `TSR_RC_CHAN;
            end else if (is_fifo) begin
              // fifo read of all stored samples
              if (fill_ff > cmd_i.dest) begin
                rsp_o.ret <= `TSR_RC_SMALL;
              end else begin
                busy_o    <= 1'b1;
                cst_ff    <= TSR_C_ISS;
                rsp_o.ret <= `TSR_RC_FIRST;
                rsp_o.len <= fill_ff;
                rch_ff    <= cmd_i.chan;
                rleft_ff  <= fill_ff;
                ridx_ff   <= (wp_ff >= 16'(fill_ff))
                             ? wp_ff - 16'(fill_ff)
                             : 16'(17'(wp_ff) + 17'(`TSR_FIFO_DEP) - fill_ff);
              end
            // scope read from the host offset
            end else if (17'(cmd_i.offset) >= rlen_ff) begin
              rsp_o.ret <= `TSR_RC_OFFS;
            end else begin
              busy_o    <= 1'b1;
              cst_ff    <= TSR_C_ISS;
              rsp_o.ret <= `TSR_RC_FIRST;
              rch_ff    <= cmd_i.chan;
              ridx_ff   <= (start_ff + cmd_i.offset) & mask;
              rleft_ff  <= (cmd_i.len > rlen_ff - 17'(cmd_i.offset))
                           ? rlen_ff - 17'(cmd_i.offset) : cmd_i.len;
              rsp_o.len <= (cmd_i.len > rlen_ff - 17'(cmd_i.offset))
                           ? rlen_ff - 17'(cmd_i.offset) : cmd_i.len;
            end
          end
        end
        TSR_C_START: begin
          if (rec_ff == TSR_R_OFF) begin
            busy_o    <= 1'b0;
            cst_ff    <= TSR_C_IDLE;
            rsp_o.ret <= `TSR_RC_STOP;
          end else if (rec_ff == TSR_R_DONE && !wbusy_ff) begin
            busy_o    <= 1'b0;
            cst_ff    <= TSR_C_IDLE;
            rsp_o.ret <= `TSR_RC_OK;
          end else if (rec_ff == TSR_R_POST) begin
            rsp_o.ret <= `TSR_RC_TRIG;
          end
        end
        TSR_C_ISS: begin
          if (rleft_ff == '0) begin
            busy_o    <= 1'b0;
            cst_ff    <= TSR_C_IDLE;
            rsp_o.ret <= ovf_ff ? `TSR_RC_OVF : `TSR_RC_OK;
          end else begin
            raddr_ff <= addr_f(rch_ff, ridx_ff, lg, is_fifo);
            cst_ff   <= TSR_C_WAIT;
          end
        end
        TSR_C_WAIT: begin
          cst_ff <= TSR_C_LAT;
        end
        TSR_C_LAT: begin
          cst_ff <= TSR_C_PUSH;
        end
        TSR_C_PUSH: begin
          if (push_ok) begin
            cst_ff   <= TSR_C_ISS;
            rleft_ff <= rleft_ff - 17'd1;
            if (is_fifo) begin
              ridx_ff <= (ridx_ff == 16'(`TSR_FIFO_DEP - 1)) ? '0
                         : ridx_ff + 16'd1;
            end else begin
              ridx_ff <= (ridx_ff + 16'd1) & mask;
            end
          end
        end
      endcase
    end
  end

  // diagnostic interrupt on both error edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      diag_q_ff  <= 1'b0;
      diag_irq_o <= 1'b0;
    end else begin
      diag_q_ff  <= diag_err_i;
      diag_irq_o <= mode_ff[6] && (diag_q_ff != diag_err_i);
    end
  end

  // per-channel limit supervision
  for (genvar c = 0; c < 8; c++) begin : g_lim
    logic out_w;
    assign out_w = ($signed(smp_i[c]) > $signed(up_ff[c]))
                   || ($signed(smp_i[c]) < $signed(lo_ff[c]));
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        in_win_ff[c]  <= 1'b1;
        proc_irq_o[c] <= 1'b0;
      end else begin
        in_win_ff[c] <= !out_w;
        // set on leaving window, wins over ack
        if (mode_ff[8+c] && !is_fifo && !is_scope && in_win_ff[c]
            && out_w) begin
          proc_irq_o[c] <= 1'b1;
        end else if (proc_ack_i[c]) begin
          proc_irq_o[c] <= 1'b0;
        end
      end
    end
  end
endmodule : tsr_top

// ### verification/tsr_monitor.sv
`timescale 1ns/100ps
module tsr_monitor
  import tsr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        diag_err_i,
  input wire logic [7:0]  proc_ack_i,
  input wire logic        req_i,
  input wire logic        busy_o,
  input wire tsr_rsp_t    rsp_o,
  input wire logic        rd_valid_o,
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_ready_i,
  input wire logic        diag_irq_o,
  input wire logic [7:0]  proc_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // command, interrupt and read port relations
  AST_BUSY_CODE: assert property (
    busy_o |-> rsp_o.ret[15:12] == 4'h7) else $error("busy code");
  AST_DONE_CODE: assert property (
    $fell(busy_o) |-> rsp_o.ret[15:12] != 4'h7) else $error("final code");
  AST_BUSY_CAUSE: assert property (
    $rose(busy_o) |-> $past(req_i)) else $error("busy without request");
  AST_FIRST_CODE: assert property (
    $rose(busy_o) |-> rsp_o.ret inside {16'h7001, 16'h7013, 16'h7023})
    else $error("first code");
  AST_RSP_STAND: assert property (
    !busy_o && !$past(busy_o) && !$past(req_i) |-> $stable(rsp_o))
    else $error("response moved");
  AST_ACK_CLR: assert property (
    !(|($past(proc_irq_o) & ~proc_irq_o & ~$past(proc_ack_i))))
    else $error("irq cleared without ack");
  AST_DIAG_CAUSE: assert property (
    diag_irq_o |-> $past(diag_err_i) != $past(diag_err_i, 2))
    else $error("diag irq without change");
  AST_RD_HOLD: assert property (
    rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("read word dropped");
  // main scenarios reached
  cover property ($rose(busy_o));
  cover property ($rose(proc_irq_o[0]));
  cover property (rd_valid_o && rd_ready_i);
endmodule : tsr_monitor

// ### verification/tsr_host.sv
`timescale 1ns/100ps
module tsr_host (
  input  wire logic        clk_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] data_i,
  input  wire logic        stall_i,
  output logic             ready_o
);
  logic [15:0] q[$];
  // words of the one channel asked for
  always @(posedge clk_i) if (valid_i && ready_o) q.push_back(data_i);
  // ready stalls every other cycle when asked
  initial ready_o = 1'b0;
  always @(negedge clk_i) ready_o <= stall_i ? !ready_o : 1'b1;
endmodule : tsr_host

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tsr_pkg::*;
  logic        clk_i, rst_n_i, prm_wr_i, diag_err_i, req_i, busy_o;
  logic        rd_valid_o, rd_ready_i, diag_irq_o, stall;
  logic [7:0]  prm_rec_i, proc_ack_i, proc_irq_o;
  logic [39:0] prm_data_i;
  logic [15:0] rd_data_o;
  tsr_smp_t    smp_i;
  tsr_cmd_t    cmd_i;
  tsr_rsp_t    rsp_o;
  int          errors, compares, i;
  time         t0, ts;
  tsr_top #(.STEP_CYC(10), .FIFO_D(8)) tsr_top_inst (.*);
  tsr_host tsr_host_inst (.clk_i(clk_i), .valid_i(rd_valid_o),
    .data_i(rd_data_o), .stall_i(stall), .ready_o(rd_ready_i));
  // compare and count
  task chk(input logic [79:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // one-cycle record write
  task prm(input logic [7:0] r, input logic [39:0] d);
    @(negedge clk_i);
    {prm_wr_i, prm_rec_i, prm_data_i} = {1'b1, r, d};
    @(negedge clk_i);
    prm_wr_i = 1'b0;
  endtask : prm
  // request held over one taking edge
  task issue(input logic [7:0] m, input logic [2:0] c,
             input logic [15:0] o, input logic [16:0] l, d);
    @(negedge clk_i);
    {req_i, cmd_i} = {1'b1, m, c, o, l, d};
    @(negedge clk_i);
    req_i = 1'b0;
  endtask : issue
  // bounded wait for busy low, then the code
  task done(input logic [15:0] e);
    for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(negedge clk_i);
    if (i == 3000) begin
      errors++;
      finish_test();
    end
    chk(rsp_o.ret, e);
  endtask : done
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, prm_wr_i, prm_rec_i, prm_data_i, diag_err_i} = '0;
    {proc_ack_i, req_i, cmd_i, smp_i, stall} = '0;
    errors = 0;
    compares = 0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    t0 = $time;
    chk({busy_o, rsp_o, proc_irq_o, diag_irq_o}, '0);
    // limit window on channel 0, diag enabled, standard mode
    prm(8'hA0, 40'h00_00FF_0001);
    prm(8'h7F, 40'h00_0000_0140);
    for (i = 0; i < 8; i++) smp_i[i] = 16'h0200 + 16'(i);
    repeat (12) @(negedge clk_i);
    chk(proc_irq_o, 8'h01);
    proc_ack_i = 8'h01;
    @(negedge clk_i);
    proc_ack_i = 8'h00;
    @(negedge clk_i);
    chk(proc_irq_o, 8'h00);
    repeat (2) begin
      diag_err_i = ~diag_err_i;
      @(negedge clk_i);
      chk(diag_irq_o, 1'b1);
      @(negedge clk_i);
      chk(diag_irq_o, 1'b0);
    end
    issue(8'h01, 3'h0, 16'h0000, 17'h0_0000, 17'h0_0000);
    done(16'h8002);
    // fifo mode, channel 0 leaves its window again
    smp_i[0] = 16'h0000;
    prm(8'h7F, 40'h00_0000_0102);
    smp_i[0] = 16'h0200;
    issue(8'h80, 3'h3, 16'h0000, 17'h0_0000, 17'h1_FFFF);
    done(16'h0004);
    issue(8'h01, 3'h6, 16'h0000, 17'h0_0000, 17'h0_0000);
    done(16'h0000);
    repeat (100) @(negedge clk_i);
    chk(proc_irq_o, 8'h00);
    stall = 1'b1;
    issue(8'h00, 3'h3, 16'hFFFF, 17'h0_0000, 17'h1_FFFF);
    done(16'h0000);
    repeat (8) @(negedge clk_i);
    chk(tsr_host_inst.q.size(), rsp_o.len);
    chk(tsr_host_inst.q.size() > 5, 1'b1);
    foreach (tsr_host_inst.q[k]) chk(tsr_host_inst.q[k], 16'h0203);
    repeat (100) @(negedge clk_i);
    issue(8'h80, 3'h3, 16'h0000, 17'h0_0000, 17'h0_0001);
    done(16'h8200);
    // one channel scope, manual start with odd trigger settings
    tsr_host_inst.q.delete();
    prm(8'h7F, 40'h00_0000_0008);
    prm(8'hBE, 40'h02_FF7E_6407);
    issue(8'h01, 3'h5, 16'h0000, 17'h0_0004, 17'h0_0000);
    chk({busy_o, rsp_o.ret}, 17'h1_7013);
    done(16'h0000);
    issue(8'h80, 3'h0, 16'h0001, 17'h0_0002, 17'h0_0064);
    done(16'h0000);
    repeat (8) @(negedge clk_i);
    chk(rsp_o.len, 17'h0_0002);
    chk({tsr_host_inst.q[0], tsr_host_inst.q[1]}, 32'h0200_0200);
    issue(8'h80, 3'h1, 16'h0000, 17'h0_0001, 17'h0_0064);
    done(16'h8005);
    issue(8'h80, 3'h0, 16'h0004, 17'h0_0001, 17'h0_0064);
    done(16'h8007);
    // rising edge trigger on channel 0, then stopped by a record write
    prm(8'hBE, 40'h00_0001_0000);
    smp_i[0] = 16'h0000;
    issue(8'h01, 3'h0, 16'h0000, 17'h0_0000, 17'h0_0000);
    chk(rsp_o.ret, 16'h7023);
    repeat (30) @(negedge clk_i);
    smp_i[0] = 16'h0200;
    ts = $time;
    repeat (30) @(negedge clk_i);
    chk(rsp_o.ret, 16'h7013);
    chk(rsp_o.tstamp - 32'((ts - t0) / 1000) <= 32'd1, 1'b1);
    prm(8'hBE, 40'h00_0001_0000);
    done(16'h8003);
    finish_test();
  end
endmodule : testbench
bind tsr_top tsr_monitor tsr_monitor_inst (.*);
